/* File: design/acfg_cfg.svh */
// constants for the converter setup register bank
// assumes the includer works on 16-bit words over a 32-bit apb bus
`ifndef ACFG_CFG_SVH
`define ACFG_CFG_SVH
// address bits that pick the word, and the first bit above them
`define ACFG_PIDX       9:2
`define ACFG_PHI        10
// register indices, byte address is four times
`define ACFG_IDX_CTRL   8'h00
`define ACFG_IDX_DATA1  8'h01
`define ACFG_IDX_SET1A  8'h02
`define ACFG_IDX_SET1B  8'h03
`define ACFG_IDX_DATA2  8'h04
`define ACFG_IDX_SET2A  8'h05
`define ACFG_IDX_SET2B  8'h06
`define ACFG_IDX_DATAT  8'h07
`define ACFG_IDX_SETTA  8'h08
`define ACFG_IDX_SETTB  8'h09
// writable masks
`define ACFG_MASK_CTRL  16'h0f07
`define ACFG_MASK_CHA   16'hff7f
`define ACFG_MASK_CHB   16'h0073
`define ACFG_MASK_TA    16'h077f
`define ACFG_MASK_TB    16'h0070
// reset values
`define ACFG_RST_A      16'h0000
`define ACFG_RST_B      16'h0070
// field positions
`define ACFG_GAIN       15:11
`define ACFG_CLKDIV     10:8
`define ACFG_RES        6:4
`define ACFG_OFS        3:0
`define ACFG_BIAS       6:4
`define ACFG_VREF       1:0
`define ACFG_SRC        11:8
`define ACFG_GO1        2
`define ACFG_GO2        1
`define ACFG_GOT        0
// source codes and gain
`define ACFG_SE_DIFF    4'h0
`define ACFG_SE_BG      4'h1
`define ACFG_SE_SMALL   4'h2
`define ACFG_SE_LARGE   4'h3
`define ACFG_SE_VDD     4'h4
`define ACFG_SE_GND     4'h5
`define ACFG_SE_DACS    4'h6
`define ACFG_SE_DACL    4'h7
`define ACFG_SE_POS     4'h8
`define ACFG_SE_NEG     4'h9
`define ACFG_GAIN_MIN   5'h00
`endif

/* File: design/acfg_pkg.sv */
// types for the converter setup register bank
// assumes acfg_cfg.svh is included where constants are needed
package acfg_pkg;
  // settings handed to the conversion engine
  typedef struct packed {
    logic [4:0] gain;
    logic [2:0] clk_div;
    logic [2:0] res;
    logic [3:0] offset;
    logic [2:0] bias;
    logic [1:0] vref;
  } acfg_conv_cfg_s;
  // analog routing for the converter inputs
  typedef struct packed {
    logic diff;
    logic bandgap;
    logic small_op;
    logic large_op;
    logic supply;
    logic ground;
    logic dac_small;
    logic dac_large;
    logic pos_in;
    logic neg_in;
    logic gain_fixed_07;
    logic gain_lowest;
  } acfg_route_s;
  typedef enum logic [1:0] {TGT_NONE, TGT_CH1, TGT_CH2, TGT_TEMP} acfg_target_e;
  typedef enum {ST_IDLE, ST_RUN} acfg_state_e;
endpackage

/* File: design/acfg_regs.sv */
// setup registers, start control and source decode for the converter
// assumes an apb3 master and a same-clock conversion engine
`timescale 1ns/100ps
`default_nettype none
`include "acfg_cfg.svh"

module acfg_regs #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_W-1:0]      paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // conversion engine
  output logic                        conv_start,
  output acfg_pkg::acfg_target_e      conv_target,
  output acfg_pkg::acfg_conv_cfg_s    conv_cfg,
  output acfg_pkg::acfg_route_s       conv_route,
  input  wire logic                   conv_done,
  input  wire logic [15:0]            conv_result,
  // processor stall
  output logic                        cpu_halt
);

  ////////////////////////////////////////////////////////////////////////
  // checks and helpers

  // index decode needs bits 9:2, and bit 10 upwards marks a miss
  if (ADDR_W < 11)
  begin : g_bad_addr
    $error("acfg_regs: ADDR_W must be at least 11");
  end

  // routing and gain handling for one source code
  function automatic acfg_pkg::acfg_route_s route_of(input logic [3:0] se);
    acfg_pkg::acfg_route_s r;
    r = '0;
    case (se)
      `ACFG_SE_DIFF:  r.diff = 1'b1;
      `ACFG_SE_BG:    r.bandgap = 1'b1;
      `ACFG_SE_SMALL: r.small_op = 1'b1;
      `ACFG_SE_LARGE: r.large_op = 1'b1;
      `ACFG_SE_VDD:   r.supply = 1'b1;
      `ACFG_SE_GND:   r.ground = 1'b1;
      `ACFG_SE_DACS:  r.dac_small = 1'b1;
      `ACFG_SE_DACL:  r.dac_large = 1'b1;
      `ACFG_SE_POS:   r.pos_in = 1'b1;
      `ACFG_SE_NEG:   r.neg_in = 1'b1;
      default:        r = '0;
    endcase
    r.gain_lowest   = r.bandgap;
    r.gain_fixed_07 = r.supply | r.ground | r.dac_small | r.dac_large;
    return r;
  endfunction

  // unpack a setup pair into engine settings
  function automatic acfg_pkg::acfg_conv_cfg_s cfg_of(
    input logic [15:0] a,
    input logic [15:0] b
  );
    acfg_pkg::acfg_conv_cfg_s c;
    c.gain    = a[`ACFG_GAIN];
    c.clk_div = a[`ACFG_CLKDIV];
    c.res     = a[`ACFG_RES];
    c.offset  = a[`ACFG_OFS];
    c.bias    = b[`ACFG_BIAS];
    c.vref    = b[`ACFG_VREF];
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register storage

  logic [15:0] set1a;
  logic [15:0] set1b;
  logic [15:0] set2a;
  logic [15:0] set2b;
  logic [15:0] setta;
  logic [15:0] settb;
  logic [15:0] data1;
  logic [15:0] data2;
  logic [15:0] datat;
  logic [3:0]  src_sel;
  logic        go1;
  logic        go2;
  logic        got;

  acfg_pkg::acfg_state_e  state;
  acfg_pkg::acfg_state_e  next_state;
  acfg_pkg::acfg_target_e active;

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  wire        acc    = psel & penable;
  wire        wr     = acc & pwrite;
  // word index, byte lanes within a word are not decoded
  wire [7:0]  idx    = paddr[`ACFG_PIDX];
  wire [15:0] wd     = pwdata[15:0];
  wire        hit_c  = (idx == `ACFG_IDX_CTRL);
  wire        hit_d1 = (idx == `ACFG_IDX_DATA1);
  wire        hit_1a = (idx == `ACFG_IDX_SET1A);
  wire        hit_1b = (idx == `ACFG_IDX_SET1B);
  wire        hit_d2 = (idx == `ACFG_IDX_DATA2);
  wire        hit_2a = (idx == `ACFG_IDX_SET2A);
  wire        hit_2b = (idx == `ACFG_IDX_SET2B);
  wire        hit_dt = (idx == `ACFG_IDX_DATAT);
  wire        hit_ta = (idx == `ACFG_IDX_SETTA);
  wire        hit_tb = (idx == `ACFG_IDX_SETTB);
  // any address bit above the index turns the access into a miss
  wire        hit_hi = (paddr[ADDR_W-1:`ACFG_PHI] != '0);
  wire        mapped = ~hit_hi & (hit_c | hit_d1 | hit_1a | hit_1b | hit_d2
                                  | hit_2a | hit_2b | hit_dt | hit_ta | hit_tb);
  wire        wr_ok  = wr & mapped;

  // zero wait states keep the processor path simple
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // control word, start bits read back while pending
  wire [15:0] ctrl_rd = {4'h0, src_sel, 5'h00, go1, go2, got};

  // read mux, unused bits come back as zero
  wire [15:0] rd16 =
      ({16{hit_c }} & ctrl_rd)
    | ({16{hit_d1}} & data1)
    | ({16{hit_1a}} & set1a)
    | ({16{hit_1b}} & set1b)
    | ({16{hit_d2}} & data2)
    | ({16{hit_2a}} & set2a)
    | ({16{hit_2b}} & set2b)
    | ({16{hit_dt}} & datat)
    | ({16{hit_ta}} & setta)
    | ({16{hit_tb}} & settb);

  // writes and misses read zero, so no stale word leaks onto the bus
  assign prdata = (mapped & ~pwrite) ? {16'h0000, rd16} : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // setup registers, masked so unused bits stay zero

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      set1a <= `ACFG_RST_A;
      set1b <= `ACFG_RST_B;
      set2a <= `ACFG_RST_A;
      set2b <= `ACFG_RST_B;
      setta <= `ACFG_RST_A;
      settb <= `ACFG_RST_B;
    end
    else if (wr_ok)
    begin
      if (hit_1a) set1a <= wd & `ACFG_MASK_CHA;
      if (hit_1b) set1b <= wd & `ACFG_MASK_CHB;
      if (hit_2a) set2a <= wd & `ACFG_MASK_CHA;
      if (hit_2b) set2b <= wd & `ACFG_MASK_CHB;
      if (hit_ta) setta <= wd & `ACFG_MASK_TA;
      if (hit_tb) settb <= wd & `ACFG_MASK_TB;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // start bits and source select

  wire wr_c   = wr_ok & hit_c;
  wire idle   = (state == acfg_pkg::ST_IDLE);
  wire fin    = (state == acfg_pkg::ST_RUN) & conv_done;
  wire fin1   = fin & (active == acfg_pkg::TGT_CH1);
  wire fin2   = fin & (active == acfg_pkg::TGT_CH2);
  wire fint   = fin & (active == acfg_pkg::TGT_TEMP);
  // temperature with a nonzero source has no meaning, dropped unconverted
  wire t_bad  = idle & got & ~go1 & ~go2 & (src_sel != `ACFG_SE_DIFF);
  // a write landing with the finish still sets the bit
  wire set1   = wr_c & wd[`ACFG_GO1];
  wire set2   = wr_c & wd[`ACFG_GO2];
  wire sett   = wr_c & wd[`ACFG_GOT];

  // source rewritable during a conversion, its route already captured at start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_sel <= `ACFG_SE_DIFF;
      go1     <= 1'b0;
      go2     <= 1'b0;
      got     <= 1'b0;
    end
    else
    begin
      if (wr_c)
        src_sel <= wd[`ACFG_SRC];
      go1 <= (go1 & ~fin1) | set1;
      go2 <= (go2 & ~fin2) | set2;
      got <= (got & ~(fint | t_bad)) | sett;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion sequencing, channel 1 before 2 before temperature

  wire pick1 = go1;
  wire pick2 = ~go1 & go2;
  // temperature with a nonzero source never launches
  wire pickt = ~go1 & ~go2 & got & (src_sel == `ACFG_SE_DIFF);
  wire launch = idle & (pick1 | pick2 | pickt);

  // settings for the chosen input, temperature has no gain or ref
  wire acfg_pkg::acfg_conv_cfg_s cfg1 = cfg_of(set1a, set1b);
  wire acfg_pkg::acfg_conv_cfg_s cfg2 = cfg_of(set2a, set2b);
  wire acfg_pkg::acfg_conv_cfg_s cfgt = cfg_of(setta, settb);
  wire acfg_pkg::acfg_route_s    rsel = route_of(src_sel);

  always_comb
  begin
    next_state = state;
    case (state)
      acfg_pkg::ST_IDLE: if (launch) next_state = acfg_pkg::ST_RUN;
      acfg_pkg::ST_RUN:  if (conv_done) next_state = acfg_pkg::ST_IDLE;
      default:           next_state = acfg_pkg::ST_IDLE;
    endcase
  end

  // snapshot at launch so rewrites mid-conversion do no harm
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state      <= acfg_pkg::ST_IDLE;
      active     <= acfg_pkg::TGT_NONE;
      conv_start <= 1'b0;
      conv_cfg   <= '0;
      conv_route <= '0;
    end
    else
    begin
      state      <= next_state;
      conv_start <= launch;
      if (launch)
      begin
        if (pick1)
        begin
          active   <= acfg_pkg::TGT_CH1;
          conv_cfg <= cfg1;
        end
        else if (pick2)
        begin
          active   <= acfg_pkg::TGT_CH2;
          conv_cfg <= cfg2;
        end
        else
        begin
          active   <= acfg_pkg::TGT_TEMP;
          conv_cfg <= '{gain: `ACFG_GAIN_MIN, vref: 2'b00, clk_div: cfgt.clk_div,
                        res: cfgt.res, offset: cfgt.offset, bias: cfgt.bias};
        end
        // the sensor has its own path, so no source routing for temperature
        conv_route <= pickt ? acfg_pkg::acfg_route_s'(0) : rsel;
      end
      else if (fin)
        active <= acfg_pkg::TGT_NONE;
    end
  end

  assign conv_target = active;

  // the programmed gain code passes through unchanged
  // fixed 0.7 and lowest gain ride on the route flags instead
  // limitation: the engine must honour those flags over conv_cfg.gain

  ////////////////////////////////////////////////////////////////////////
  // result capture

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data1 <= 16'h0000;
      data2 <= 16'h0000;
      datat <= 16'h0000;
    end
    else
    begin
      if (fin1) data1 <= conv_result;
      if (fin2) data2 <= conv_result;
      // temperature result lands in its own word
      if (fint) datat <= conv_result;
    end
  end

  // stall covers pending requests so the processor never runs ahead
  assign cpu_halt = go1 | go2 | pickt | ~idle;

endmodule // acfg_regs

`default_nettype wire

/* File: dv/acfg_regs_assertions.sv */
// checker for the converter setup bank, bound into acfg_regs
// assumes it sees only the ports of acfg_regs
`timescale 1ns/100ps
`default_nettype none
module acfg_chk #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic                     pclk,
  input wire logic                     presetn,
  // apb
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [ADDR_W-1:0]        paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pslverr,
  // engine side
  input wire logic                     conv_start,
  input wire acfg_pkg::acfg_target_e   conv_target,
  input wire acfg_pkg::acfg_conv_cfg_s conv_cfg,
  input wire acfg_pkg::acfg_route_s    conv_route,
  input wire logic                     conv_done,
  input wire logic                     cpu_halt
);
  logic run_seen;
  wire  rd_acc = psel && penable && !pwrite;
  // remember a launched conversion until its finish
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) run_seen <= 1'b0;
    else if (conv_done) run_seen <= 1'b0;
    else if (conv_start) run_seen <= 1'b1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  a_cfg_held: assert property (
    (run_seen || conv_start) && !conv_done |=> $stable(conv_cfg) && $stable(conv_route))
    else $error("setup moved during conversion");
  a_temp_zero: assert property (
    conv_start && conv_target == acfg_pkg::TGT_TEMP |-> conv_route == 12'h000
      && conv_cfg.gain == 5'h00 && conv_cfg.vref == 2'h0) else $error("temp setup not clean");
  a_fixed_gain: assert property (
    conv_start && conv_target != acfg_pkg::TGT_TEMP |-> conv_route.gain_fixed_07 ==
      (conv_route.supply || conv_route.ground || conv_route.dac_small || conv_route.dac_large))
    else $error("fixed gain flag wrong");
  a_bg_lowest: assert property (
    conv_start && conv_route.bandgap |-> conv_route.gain_lowest && !conv_route.gain_fixed_07)
    else $error("bandgap gain wrong");
  a_unused_a: assert property (
    rd_acc && (paddr == 12'h008 || paddr == 12'h014) |-> (prdata & 32'hffff0080) == 32'h0)
    else $error("setup a unused bit set");
  a_unused_b: assert property (
    rd_acc && (paddr == 12'h00c || paddr == 12'h018) |-> (prdata & 32'hffffff8c) == 32'h0)
    else $error("setup b unused bit set");
  a_unused_ta: assert property (
    rd_acc && paddr == 12'h020 |-> (prdata & 32'hfffff880) == 32'h0)
    else $error("temp a unused bit set");
  a_unused_tb: assert property (
    rd_acc && paddr == 12'h024 |-> (prdata & 32'hffffff8f) == 32'h0)
    else $error("temp b unused bit set");
  a_done_clear: assert property (
    conv_done && conv_target != acfg_pkg::TGT_NONE |=>
      conv_target == acfg_pkg::TGT_NONE && !conv_start) else $error("finish not taken");
  a_start_once: assert property (
    conv_start |=> !conv_start) else $error("start longer than a pulse");
  a_write_halt: assert property (
    psel && penable && pwrite && paddr == 12'h000 && (pwdata[2] || pwdata[1]) |=> cpu_halt)
    else $error("no halt after start");
  // main scenarios seen
  c_ch1: cover property (conv_start && conv_target == acfg_pkg::TGT_CH1);
  c_ch2: cover property (conv_start && conv_target == acfg_pkg::TGT_CH2);
  c_tmp: cover property (conv_start && conv_target == acfg_pkg::TGT_TEMP);
  c_err: cover property (psel && penable && pslverr);
endmodule // acfg_chk
bind acfg_regs acfg_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pslverr(pslverr), .conv_start(conv_start), .conv_target(conv_target),
  .conv_cfg(conv_cfg), .conv_route(conv_route), .conv_done(conv_done), .cpu_halt(cpu_halt));
`default_nettype wire

/* File: dv/adc_channel_config_regs_test.sv */
// self-checking bench for the converter setup bank
// assumes acfg_regs alone; the bench stands in for the engine
`timescale 1ns/100ps
`default_nettype none
module adc_channel_config_regs_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, conv_done = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] conv_result = 16'h0, sa, sb, res_q;
  logic        pready, pslverr, conv_start, cpu_halt, err;
  acfg_pkg::acfg_target_e   conv_target;
  acfg_pkg::acfg_conv_cfg_s conv_cfg;
  acfg_pkg::acfg_route_s    conv_route;
  integer seed = 36, errors = 0, cmp_count = 0, n_start = 0, eng_cnt = 0, i, s0;
  logic [7:0] tbl [0:5] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h08, 8'h09};
  always #4 pclk = ~pclk;
  acfg_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_start(conv_start), .conv_target(conv_target),
    .conv_cfg(conv_cfg), .conv_route(conv_route), .conv_done(conv_done),
    .conv_result(conv_result), .cpu_halt(cpu_halt));
  ////////////////////////////////////////////////////////////////
  // engine stand-in: random latency so finish lands at varied points
  // latency of three or more so setup rewrites land mid-conversion
  always @(posedge pclk)
  begin
    conv_done <= (conv_start !== 1'b1) && (eng_cnt == 1);
    if (conv_start === 1'b1)
    begin
      n_start <= n_start + 1;
      eng_cnt <= 3 + {$random(seed)} % 6;
    end
    else if (eng_cnt == 1)
    begin
      res_q = 16'($random(seed));
      conv_result <= res_q;
      eng_cnt <= 0;
    end
    else if (eng_cnt > 1) eng_cnt <= eng_cnt - 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; holds everything until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [15:0] mask(input logic [7:0] idx);
    case (idx)
      8'h02, 8'h05: mask = 16'hff7f;
      8'h03, 8'h06: mask = 16'h0073;
      8'h08:        mask = 16'h077f;
      8'h09:        mask = 16'h0070;
      default:      mask = 16'h0000;
    endcase
  endfunction
  function automatic logic [11:0] route(input logic [3:0] se);
    route = 12'h800 >> se;
    route[1] = (se >= 4 && se <= 7);
    route[0] = (se == 1);
  endfunction
  task automatic wait_idle;
    integer n;
    n = 0;
    @(posedge pclk);
    while (cpu_halt !== 1'b0 && n < 200) begin @(posedge pclk); n++; end
    chk({31'h0, cpu_halt}, 32'h0);
  endtask
  // setup a/b at ia, start, check snapshot, rewrite mid-run, check result
  task automatic conv(input logic [7:0] ia, input logic [2:0] go, input logic [3:0] se);
    integer n;
    logic [19:0] ec;
    sa = 16'($random(seed));
    sb = 16'($random(seed));
    apb(1'b1, ia, sa);
    apb(1'b1, ia + 8'h01, sb);
    apb(1'b1, 8'h00, {4'h0, se, 5'h00, go});
    n = 0;
    while (conv_start !== 1'b1 && n < 20) begin @(posedge pclk); n++; end
    chk({31'h0, conv_start}, 32'h1);
    ec = {sa[15:11], sa[10:8], sa[6:4], sa[3:0], sb[6:4], sb[1:0]};
    if (go == 3'h1) ec = {5'h00, ec[14:2], 2'h0};
    chk({30'h0, conv_target}, (go == 3'h4) ? 32'h1 : (go == 3'h2) ? 32'h2 : 32'h3);
    chk({12'h0, conv_cfg}, {12'h0, ec});
    chk({20'h0, conv_route}, {20'h0, (go == 3'h1) ? 12'h000 : route(se)});
    apb(1'b1, ia, ~sa);
    wait_idle;
    chk({12'h0, conv_cfg}, {12'h0, ec});
    apb(1'b0, ia - 8'h01, 16'h0000);
    chk(rd, {16'h0, res_q});
    apb(1'b0, 8'h00, 16'h0000);
    chk(rd, {20'h0, se, 8'h00});
  endtask
  task close_out;
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 10; i++)
    begin
      apb(1'b0, i[7:0], 16'h0000);
      chk(rd, (i % 3 == 0 && i > 0) ? 32'h70 : 32'h0);
    end
    apb(1'b0, 8'h0a, 16'h0000);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
    for (i = 0; i < 24; i++)
    begin
      s0 = tbl[{$random(seed)} % 6];
      sa = (i < 6) ? 16'hffff : 16'($random(seed));
      apb(1'b1, s0[7:0], sa);
      apb(1'b0, s0[7:0], 16'h0000);
      chk(rd, {16'h0, sa & mask(s0[7:0])});
    end
    $display("test masks done");
    for (i = 0; i < 10; i++) conv(i[0] ? 8'h05 : 8'h02, i[0] ? 3'h2 : 3'h4, i[3:0]);
    conv(8'h08, 3'h1, 4'h0);
    $display("test sources done");
    s0 = n_start;
    apb(1'b1, 8'h00, 16'h0301);
    repeat (3) @(posedge pclk);
    apb(1'b0, 8'h00, 16'h0000);
    chk(rd, 32'h0300);
    apb(1'b1, 8'h00, 16'h0007);
    wait_idle;
    chk(n_start - s0, 32'h3);
    $display("test starts done");
    close_out;
  end
  // watchdog far beyond the expected several hundred cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    close_out;
  end
endmodule // adc_channel_config_regs_test
`default_nettype wire
